// >>> rtl/tcs_defs.vh
// tcs_defs.vh: register map, field positions, reset values and timing counts
// assumes: included by bare name from the serial slave and sequencer top design files
`ifndef TCS_DEFS_VH
`define TCS_DEFS_VH
// ========
// register map: byte address = {region, index, 2'b00}
`define TCS_RGN_CTRL 3'h0
`define TCS_RGN_RESULT 3'h1
`define TCS_RGN_THI 3'h2
`define TCS_RGN_TLO 3'h3
`define TCS_IDX_CONFIG 3'h0
`define TCS_IDX_STATUS 3'h1
`define TCS_IDX_SLVADDR 3'h2
`define TCS_OFS_BAD 8'hFC
// ========
// fields
`define TCS_CFG_START 0
`define TCS_CFG_AUTO 1
`define TCS_CFG_STOP 6
`define TCS_ST_SLEEP 6
`define TCS_ST_BUSY 7
`define TCS_ST_HI_LSB 8
`define TCS_ST_LO_LSB 16
// ========
// reset values
`define TCS_RST_CONFIG 8'h00
`define TCS_RST_RESULT 8'h00
`define TCS_RST_THI 8'h7F
`define TCS_RST_TLO 8'hC9
// ========
// serial side
`define TCS_SMB_ADDR_BASE 7'h18
`define TCS_CMD_START 8'h0F
`define TCS_RESP_OKAY 2'h0
`define TCS_RESP_SLVERR 2'h2
// ========
// timing
`define TCS_CAP_DELAY 2'h3
`define TCS_INTEG_MS 64
`define TCS_CLK_KHZ 100000
`define TCS_INTEG_CYC (`TCS_INTEG_MS * `TCS_CLK_KHZ)
`endif

// >>> rtl/tcs_alarm_cmp.v
// tcs_alarm_cmp.v: per-channel window comparison of results against thresholds
// assumes: values are two's complement, one degree per step
`timescale 1ns/100ps
`default_nettype none

module tcs_alarm_cmp #(
    parameter NCH = 5
) (
    // packed channel values, channel 0 in the low byte
    input wire [8*NCH-1:0] temp_vec,
    input wire [8*NCH-1:0] thi_vec,
    input wire [8*NCH-1:0] tlo_vec,
    // flags
    output wire [NCH-1:0] over,
    output wire [NCH-1:0] under
);

genvar i;
generate
    for (i = 0; i < NCH; i = i + 1) begin : g_cmp
        // signed so that sub-zero readings order correctly
        assign over[i] = $signed(temp_vec[8*i +: 8]) > $signed(thi_vec[8*i +: 8]);
        assign under[i] = $signed(temp_vec[8*i +: 8]) < $signed(tlo_vec[8*i +: 8]);
    end
endgenerate

endmodule // tcs_alarm_cmp
`default_nettype wire

// >>> rtl/tcs_smb_slave.v
// tcs_smb_slave.v: byte-protocol serial slave (write/read/send/receive byte)
// assumes: host drives the clock; pins arrive unsynchronised
`timescale 1ns/100ps
`default_nettype none
`include "tcs_defs.vh"

module tcs_smb_slave (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // bus pins
    input wire scl_in,
    input wire sda_in,
    output reg sda_oe_n_reg,
    // register side
    input wire [6:0] own_addr,
    input wire [7:0] rd_byte,
    output reg [7:0] ptr_reg,
    output reg cmd_stb_reg,
    output reg wr_stb_reg,
    output reg [7:0] wr_byte_reg
);

localparam S_IDLE = 3'd0;
localparam S_RX = 3'd1;
localparam S_ACK = 3'd2;
localparam S_TX = 3'd3;
localparam S_WAIT = 3'd4;

// ========
// pin synchronisers
reg [1:0] scl_s_reg;
reg [1:0] sda_s_reg;
reg scl_d_reg;
reg sda_d_reg;
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        scl_s_reg <= 2'b11;
        sda_s_reg <= 2'b11;
        scl_d_reg <= 1'b1;
        sda_d_reg <= 1'b1;
    end else begin
        scl_s_reg <= {scl_s_reg[0], scl_in};
        sda_s_reg <= {sda_s_reg[0], sda_in};
        scl_d_reg <= scl_s_reg[1];
        sda_d_reg <= sda_s_reg[1];
    end
end
wire scl = scl_s_reg[1];
wire sda = sda_s_reg[1];
wire scl_rise = scl & ~scl_d_reg;
wire scl_fall = ~scl & scl_d_reg;
wire start = scl & scl_d_reg & sda_d_reg & ~sda;
wire stop = scl & scl_d_reg & ~sda_d_reg & sda;

// ========
// byte engine
reg [2:0] state_reg;
reg [7:0] sh_reg;
reg [3:0] cnt_reg;
reg rw_reg;
reg addr_ph_reg;
reg first_reg;
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        state_reg <= S_IDLE;
        sh_reg <= 8'h00;
        cnt_reg <= 4'h0;
        rw_reg <= 1'b0;
        addr_ph_reg <= 1'b0;
        first_reg <= 1'b0;
        sda_oe_n_reg <= 1'b1;
        ptr_reg <= 8'h00;
        cmd_stb_reg <= 1'b0;
        wr_stb_reg <= 1'b0;
        wr_byte_reg <= 8'h00;
    end else begin
        cmd_stb_reg <= 1'b0;
        wr_stb_reg <= 1'b0;
        // repeated start lands here too
        if (start) begin
            state_reg <= S_RX;
            cnt_reg <= 4'h0;
            addr_ph_reg <= 1'b1;
            sda_oe_n_reg <= 1'b1;
        end else if (stop) begin
            state_reg <= S_IDLE;
            sda_oe_n_reg <= 1'b1;
        end else begin
            case (state_reg)
                S_RX: begin
                    if (scl_rise) begin
                        sh_reg <= {sh_reg[6:0], sda};
                        cnt_reg <= cnt_reg + 4'h1;
                    end else if (scl_fall && cnt_reg == 4'h8) begin
                        cnt_reg <= 4'h0;
                        if (addr_ph_reg) begin
                            if (sh_reg[7:1] == own_addr) begin
                                rw_reg <= sh_reg[0];
                                first_reg <= ~sh_reg[0];
                                sda_oe_n_reg <= 1'b0;
                                state_reg <= S_ACK;
                            end else begin
                                state_reg <= S_WAIT;
                            end
                        end else begin
                            sda_oe_n_reg <= 1'b0;
                            state_reg <= S_ACK;
                            first_reg <= 1'b0;
                            if (first_reg) begin
                                ptr_reg <= sh_reg;
                                cmd_stb_reg <= 1'b1;
                            end else begin
                                wr_byte_reg <= sh_reg;
                                wr_stb_reg <= 1'b1;
                            end
                        end
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        addr_ph_reg <= 1'b0;
                        if (addr_ph_reg && rw_reg) begin
                            // receive byte returns the last selected register
                            sh_reg <= {rd_byte[6:0], 1'b0};
                            sda_oe_n_reg <= rd_byte[7];
                            cnt_reg <= 4'h1;
                            state_reg <= S_TX;
                        end else begin
                            sda_oe_n_reg <= 1'b1;
                            state_reg <= S_RX;
                        end
                    end
                end
                S_TX: begin
                    if (scl_fall) begin
                        if (cnt_reg == 4'h8) begin
                            sda_oe_n_reg <= 1'b1;
                            state_reg <= S_WAIT;
                        end else begin
                            sda_oe_n_reg <= sh_reg[7];
                            sh_reg <= {sh_reg[6:0], 1'b0};
                            cnt_reg <= cnt_reg + 4'h1;
                        end
                    end
                end
                S_WAIT, S_IDLE: begin
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end
end

endmodule // tcs_smb_slave
`default_nettype wire

// >>> rtl/tcs_seq_top.v
// tcs_seq_top.v: conversion sequencer, result/threshold store, AXI4-Lite slave
// assumes: adc front end on clk holds a settled 8-bit reading for adc_chan_sel
//
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "tcs_defs.vh"

module tcs_seq_top #(
    parameter NUM_REMOTE = 4,
    parameter [31:0] INTEG_CYCLES = `TCS_INTEG_CYC
) (
    // clock and reset
    input wire clk,
    input wire nrst,
    // axi4-lite write
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // serial pins
    input wire serial_clock_in,
    input wire serial_data_io_in,
    output reg serial_data_io_out,
    output wire serial_data_io_oe_n,
    // alert pin
    input wire alert_in,
    output reg alert_out,
    output reg alert_oe_n,
    // standby and address straps
    input wire hw_sleep_n,
    input wire slave_addr_select_lo,
    input wire slave_addr_select_hi,
    // adc front end
    input wire [7:0] adc_result_in,
    output reg [2:0] adc_chan_sel,
    output reg adc_enable
);

localparam NCH = NUM_REMOTE + 1;
localparam [1:0] S_IDLE = 2'b00;
localparam [1:0] S_CONV = 2'b01;
localparam [31:0] LAST_TICK = INTEG_CYCLES - 32'h1;
localparam [31:0] NCH_M1 = NCH - 1;
localparam [2:0] LAST_CH = NCH_M1[2:0];
localparam [7:0] CFG_MASK = ~(8'h01 << `TCS_CFG_START);

// ========
// reset release and pin synchronisers
reg [1:0] rst_sync_reg;
wire rst_n = rst_sync_reg[1];
always @(posedge clk or negedge nrst) begin
    if (!nrst) rst_sync_reg <= 2'b00;
    else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
end

reg [2:0] pin_s0_reg;
reg [2:0] pin_s1_reg;
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        pin_s0_reg <= 3'h0;
        pin_s1_reg <= 3'h0;
    end else begin
        pin_s0_reg <= {slave_addr_select_hi, slave_addr_select_lo, hw_sleep_n};
        pin_s1_reg <= pin_s0_reg;
    end
end

// ========
// address strap capture, once after reset
reg [1:0] cap_cnt_reg;
reg cap_done_reg;
reg [1:0] addr_sel_reg;
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        cap_cnt_reg <= 2'h0;
        cap_done_reg <= 1'b0;
        addr_sel_reg <= 2'h0;
    end else if (!cap_done_reg) begin
        cap_cnt_reg <= cap_cnt_reg + 2'h1;
        // wait until the synchroniser holds real pin levels
        if (cap_cnt_reg == `TCS_CAP_DELAY) begin
            addr_sel_reg <= pin_s1_reg[2:1];
            cap_done_reg <= 1'b1;
        end
    end
end
wire [6:0] own_addr = `TCS_SMB_ADDR_BASE + {5'h00, addr_sel_reg};

// ========
// storage
reg [7:0] cfg_reg;
reg [7:0] res_reg [0:NCH-1];
reg [7:0] thi_reg [0:NCH-1];
reg [7:0] tlo_reg [0:NCH-1];
reg [7:0] stage_reg [0:NCH-1];
reg [NCH-1:0] over_reg;
reg [NCH-1:0] under_reg;
reg [1:0] state_reg;
reg [31:0] timer_reg;
reg busy_reg;
reg commit_reg;
reg start_pend_reg;
wire [NCH-1:0] over_w;
wire [NCH-1:0] under_w;
wire [8*NCH-1:0] stage_vec;
wire [8*NCH-1:0] thi_vec;
wire [8*NCH-1:0] tlo_vec;
// pin low overrides software; stop bit is the software standby
wire running = pin_s1_reg[0] & ~cfg_reg[`TCS_CFG_STOP];

genvar g;
generate
    for (g = 0; g < NCH; g = g + 1) begin : g_flat
        assign stage_vec[8*g +: 8] = stage_reg[g];
        assign thi_vec[8*g +: 8] = thi_reg[g];
        assign tlo_vec[8*g +: 8] = tlo_reg[g];
    end
endgenerate

// compared on staged data so flags land with the results
tcs_alarm_cmp #(.NCH(NCH)) u_cmp (
    .temp_vec(stage_vec),
    .thi_vec(thi_vec),
    .tlo_vec(tlo_vec),
    .over(over_w),
    .under(under_w)
);

// ========
// decode
function addr_hit;
    input [7:0] a;
    begin
        addr_hit = (a[1:0] == 2'b00) &&
            ((a[7:5] == `TCS_RGN_CTRL && a[4:2] <= `TCS_IDX_SLVADDR) ||
             ((a[7:5] == `TCS_RGN_RESULT || a[7:5] == `TCS_RGN_THI ||
               a[7:5] == `TCS_RGN_TLO) && a[4:2] <= LAST_CH));
    end
endfunction

function [31:0] rd_word;
    input [7:0] a;
    reg [31:0] w;
    begin
        w = 32'h0;
        if (addr_hit(a)) begin
            case (a[7:5])
                `TCS_RGN_CTRL: begin
                    if (a[4:2] == `TCS_IDX_CONFIG) w[7:0] = cfg_reg;
                    else if (a[4:2] == `TCS_IDX_SLVADDR) w[6:0] = own_addr;
                    else begin
                        w[`TCS_ST_BUSY] = busy_reg;
                        w[`TCS_ST_SLEEP] = ~running;
                        w[`TCS_ST_HI_LSB +: NCH] = over_reg;
                        w[`TCS_ST_LO_LSB +: NCH] = under_reg;
                    end
                end
                `TCS_RGN_RESULT: w[7:0] = res_reg[a[4:2]];
                `TCS_RGN_THI: w[7:0] = thi_reg[a[4:2]];
                `TCS_RGN_TLO: w[7:0] = tlo_reg[a[4:2]];
                default: w = 32'h0;
            endcase
        end
        rd_word = w;
    end
endfunction

// serial command byte {0, region, 0, index} maps onto the bus map
function [7:0] smb_addr;
    input [7:0] c;
    begin
        smb_addr = (c[7] | c[3]) ? `TCS_OFS_BAD : {c[6:4], c[2:0], 2'b00};
    end
endfunction

// ========
// serial slave
wire [7:0] smb_ptr;
wire smb_cmd_stb;
wire smb_wr_stb;
wire [7:0] smb_wr_byte;
wire [7:0] smb_waddr = smb_addr(smb_ptr);
wire [31:0] smb_rd_word = rd_word(smb_waddr);

tcs_smb_slave u_smb (
    .clk(clk),
    .rst_n(rst_n),
    .scl_in(serial_clock_in),
    .sda_in(serial_data_io_in),
    .sda_oe_n_reg(serial_data_io_oe_n),
    .own_addr(own_addr),
    .rd_byte(smb_rd_word[7:0]),
    .ptr_reg(smb_ptr),
    .cmd_stb_reg(smb_cmd_stb),
    .wr_stb_reg(smb_wr_stb),
    .wr_byte_reg(smb_wr_byte)
);

// ========
// write port, AXI write wins a same-cycle clash with a serial write
reg aw_have_reg;
reg w_have_reg;
reg [7:0] awaddr_q_reg;
reg [7:0] wdata_q_reg;
reg wstrb0_q_reg;
wire axi_do = aw_have_reg & w_have_reg & ~s_axi_bvalid;
wire we_axi = axi_do & wstrb0_q_reg & addr_hit(awaddr_q_reg);
wire we = we_axi | (smb_wr_stb & addr_hit(smb_waddr));
wire [7:0] wa = we_axi ? awaddr_q_reg : smb_waddr;
wire [7:0] wd = we_axi ? wdata_q_reg : smb_wr_byte;
wire wr_cfg = we && wa[7:5] == `TCS_RGN_CTRL && wa[4:2] == `TCS_IDX_CONFIG;
wire start_req = (wr_cfg & wd[`TCS_CFG_START]) |
    (smb_cmd_stb & (smb_ptr == `TCS_CMD_START));
wire take = (state_reg == S_IDLE) && running && !commit_reg &&
    (start_pend_reg || cfg_reg[`TCS_CFG_AUTO]);

// ========
// sequencer
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        state_reg <= S_IDLE;
        timer_reg <= 32'h0;
        busy_reg <= 1'b0;
        commit_reg <= 1'b0;
        start_pend_reg <= 1'b0;
        adc_chan_sel <= 3'h0;
        adc_enable <= 1'b0;
    end else begin
        // a new request wins over the clear by take; dropped in standby
        start_pend_reg <= running & (start_req | (start_pend_reg & ~take));
        commit_reg <= 1'b0;
        case (state_reg)
            S_IDLE: begin
                busy_reg <= 1'b0;
                if (take) begin
                    state_reg <= S_CONV;
                    timer_reg <= 32'h0;
                    adc_chan_sel <= 3'h0;
                    adc_enable <= 1'b1;
                    busy_reg <= 1'b1;
                end
            end
            S_CONV: begin
                if (!running) begin
                    // abandon: staged data never reaches the results
                    state_reg <= S_IDLE;
                    adc_enable <= 1'b0;
                end else if (timer_reg == LAST_TICK) begin
                    stage_reg[adc_chan_sel] <= adc_result_in;
                    timer_reg <= 32'h0;
                    if (adc_chan_sel == LAST_CH) begin
                        state_reg <= S_IDLE;
                        adc_enable <= 1'b0;
                        commit_reg <= 1'b1;
                    end else begin
                        adc_chan_sel <= adc_chan_sel + 3'h1;
                    end
                end else begin
                    timer_reg <= timer_reg + 32'h1;
                end
            end
            default: begin
                state_reg <= S_IDLE;
            end
        endcase
    end
end

// ========
// registers seen by software
integer i;
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        cfg_reg <= `TCS_RST_CONFIG;
        over_reg <= {NCH{1'b0}};
        under_reg <= {NCH{1'b0}};
        for (i = 0; i < NCH; i = i + 1) begin
            res_reg[i] <= `TCS_RST_RESULT;
            thi_reg[i] <= `TCS_RST_THI;
            tlo_reg[i] <= `TCS_RST_TLO;
        end
    end else begin
        if (wr_cfg) cfg_reg <= wd & CFG_MASK;
        if (we && wa[7:5] == `TCS_RGN_THI) thi_reg[wa[4:2]] <= wd;
        if (we && wa[7:5] == `TCS_RGN_TLO) tlo_reg[wa[4:2]] <= wd;
        // only a completed run touches results; standby leaves all in place
        if (commit_reg) begin
            for (i = 0; i < NCH; i = i + 1) res_reg[i] <= stage_reg[i];
            over_reg <= over_w;
            under_reg <= under_w;
        end
    end
end

// ========
// open-drain pin drive
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        alert_out <= 1'b0;
        alert_oe_n <= 1'b1;
        serial_data_io_out <= 1'b0;
    end else begin
        alert_out <= 1'b0;
        alert_oe_n <= ~(|over_reg | |under_reg);
        serial_data_io_out <= 1'b0;
    end
end

// ========
// axi4-lite slave, one write and one read at a time
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `TCS_RESP_OKAY;
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
        s_axi_rresp <= `TCS_RESP_OKAY;
        s_axi_rdata <= 32'h0;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        awaddr_q_reg <= 8'h00;
        wdata_q_reg <= 8'h00;
        wstrb0_q_reg <= 1'b0;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            awaddr_q_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            wdata_q_reg <= s_axi_wdata[7:0];
            wstrb0_q_reg <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
        end
        if (axi_do) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_hit(awaddr_q_reg) ? `TCS_RESP_OKAY : `TCS_RESP_SLVERR;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word(s_axi_araddr);
            s_axi_rresp <= addr_hit(s_axi_araddr) ? `TCS_RESP_OKAY : `TCS_RESP_SLVERR;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
end

endmodule // tcs_seq_top
`default_nettype wire

// >>> dv/tcs_host_model.sv
// tcs_host_model.sv: idle serial host facing the sequencer's bus pins
// assumes: data line has a pull-up; the device pulls low when its enable is low
`timescale 1ns/100ps
`default_nettype none

module tcs_host_model (
    // lines seen by the device
    output logic serial_clock,
    output logic serial_data,
    // device pull-down request, active low
    input wire logic dev_sda_oe_n
);
    // ==========
    // the host owns the clock; parked high between frames
    assign serial_clock = 1'b1;
    // wired-and with the pull-up: released means high
    assign serial_data = dev_sda_oe_n;
endmodule // tcs_host_model

`default_nettype wire

// >>> dv/tcs_seq_top_asserts.sv
// tcs_seq_top_asserts.sv: port-level checks for the conversion sequencer
// assumes: bound into tcs_seq_top, one clock domain
`timescale 1ns/100ps
`default_nettype none

module tcs_seq_top_asserts #(
    parameter NUM_REMOTE = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // read channel
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // pins
    input wire logic hw_sleep_n,
    input wire logic serial_data_io_out,
    input wire logic alert_out,
    input wire logic alert_oe_n,
    input wire logic [2:0] adc_chan_sel,
    input wire logic adc_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // ==========
    // properties
    property p_sda_low; serial_data_io_out == 1'b0; endproperty
    a_sda_low: assert property (p_sda_low) else $error("data pin drives high");
    property p_alert_low; alert_out == 1'b0; endproperty
    a_alert_low: assert property (p_alert_low) else $error("alert drives high");
    property p_chan_range; adc_enable |-> adc_chan_sel <= NUM_REMOTE; endproperty
    a_chan_range: assert property (p_chan_range) else $error("channel out of range");
    property p_chan_step;
        adc_enable && $past(adc_enable) && adc_chan_sel != $past(adc_chan_sel)
            |-> adc_chan_sel == $past(adc_chan_sel) + 3'h1 || adc_chan_sel == 3'h0;
    endproperty
    a_chan_step: assert property (p_chan_step) else $error("channel skipped");
    property p_sleep_stop; !hw_sleep_n [*8] |-> !adc_enable; endproperty
    a_sleep_stop: assert property (p_sleep_stop) else $error("run during standby");
    property p_ar_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_ar_ans: assert property (p_ar_ans) else $error("read not answered");
    property p_r_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_r_once: assert property (p_r_once) else $error("read answered twice");
    property p_ar_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar_busy: assert property (p_ar_busy) else $error("read taken while busy");
    c_run: cover property ($rose(adc_enable));
    c_alarm: cover property ($fell(alert_oe_n));
    c_neg: cover property (s_axi_rvalid && s_axi_rdata[7]);
endmodule // tcs_seq_top_asserts

bind tcs_seq_top tcs_seq_top_asserts #(.NUM_REMOTE(NUM_REMOTE)) chk_u (.*);

`default_nettype wire

// >>> dv/test_multichannel_temp_conversion_sequencer.sv
// test_multichannel_temp_conversion_sequencer.sv: self-checking bench
// assumes: short integration count, idle serial host, adc modelled per channel
`timescale 1ns/100ps
`default_nettype none

module test_multichannel_temp_conversion_sequencer;
    localparam NCH = 5;
    logic clk = 0, nrst = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic s_axi_bready = 1, s_axi_rready = 1, hw_sleep_n = 1;
    logic slave_addr_select_lo = 1, slave_addr_select_hi = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, adc_result_in = 0, old;
    logic [31:0] s_axi_wdata = 0, seed = 32'h8084, st;
    logic [3:0] s_axi_wstrb = 4'hF;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire serial_data_io_out, serial_data_io_oe_n, alert_out, alert_oe_n, adc_enable;
    wire serial_clock_in, serial_data_io_in, alert_in;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [2:0] adc_chan_sel;
    int failures = 0, checks_done = 0, cyc = 0, i;
    logic [33:0] q[$];
    logic [7:0] tv[8], thi[8], tlo[8];

    tcs_seq_top #(.NUM_REMOTE(4), .INTEG_CYCLES(20)) dut_u (.*);
    tcs_host_model host_u (.serial_clock(serial_clock_in), .serial_data(serial_data_io_in),
        .dev_sda_oe_n(serial_data_io_oe_n));
    // open-drain alert with pull-up
    assign alert_in = alert_oe_n;

    always #5 clk = ~clk;
    always @(posedge clk) adc_result_in <= tv[adc_chan_sel];

    // ==========
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        q.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        q.push_back({r, 32'h0});
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
    endtask

    task automatic calc;
        st = 0;
        for (int c = 0; c < NCH; c++) begin
            st[8+c] = $signed(tv[c]) > $signed(thi[c]);
            st[16+c] = $signed(tv[c]) < $signed(tlo[c]);
        end
    endtask

    // replies are matched in issue order; one transfer at a time
    always @(posedge clk) if (nrst && (s_axi_rvalid || s_axi_bvalid))
        chk("bus reply", q.pop_front(),
            s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} : {s_axi_bresp, 32'h0});

    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            failures++;
            wrap_up;
        end
    end

    // ==========
    // main sequence
    initial begin
        for (i = 0; i < 8; i++) begin
            tv[i] = 8'h00;
            thi[i] = 8'h7F;
            tlo[i] = 8'hC9;
        end
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (8) @(posedge clk);
        rd(8'h08, 34'h19);
        slave_addr_select_lo <= 1'b0;
        slave_addr_select_hi <= 1'b1;
        for (i = 0; i < NCH; i++) begin
            rd(8'(8'h20 + 4 * i), 34'h0);
            rd(8'(8'h40 + 4 * i), 34'h7F);
            rd(8'(8'h60 + 4 * i), 34'hC9);
            seed = xs(seed);
            tv[i] = seed[7:0];
        end
        tv[0][7:6] = 2'b00;
        tv[1][7] = 1'b1;
        thi[0] = 8'h80;
        tlo[1] = 8'h7F;
        wr(8'h40, 8'h80, 2'h0);
        wr(8'h64, 8'h7F, 2'h0);
        wr(8'hFC, 8'h00, 2'h2);
        wr(8'h20, 8'h55, 2'h0);
        rd(8'h08, 34'h19);
        rd(8'hFC, {2'h2, 32'h0});
        wr(8'h00, 8'h01, 2'h0);
        repeat (2) @(posedge clk);
        rd(8'h04, 34'h80);
        rd(8'h20, 34'h0);
        while (adc_enable) @(posedge clk);
        repeat (4) @(posedge clk);
        calc;
        for (i = 0; i < NCH; i++) rd(8'(8'h20 + 4 * i), {26'h0, tv[i]});
        rd(8'h04, {2'h0, st});
        chk("alert pin", 34'h0, {33'h0, alert_oe_n});
        old = tv[2];
        tv[2] = ~tv[2];
        wr(8'h00, 8'h01, 2'h0);
        repeat (30) @(posedge clk);
        hw_sleep_n <= 1'b0;
        repeat (10) @(posedge clk);
        wr(8'h00, 8'h01, 2'h0);
        repeat (5) @(posedge clk);
        rd(8'h28, {26'h0, old});
        rd(8'h04, {2'h0, st | 32'h40});
        hw_sleep_n <= 1'b1;
        wr(8'h00, 8'h02, 2'h0);
        repeat (8) @(posedge clk);
        rd(8'h04, {2'h0, st | 32'h80});
        wr(8'h00, 8'h42, 2'h0);
        repeat (4) @(posedge clk);
        rd(8'h04, {2'h0, st | 32'h40});
        rd(8'h28, {26'h0, old});
        chk("data pin enable", 34'h1, {33'h0, serial_data_io_oe_n});
        wrap_up;
    end
endmodule // test_multichannel_temp_conversion_sequencer

`default_nettype wire
